// File: src/ptc_top.sv
/*
  Pixel tone correction: balance ratio, white clip, gamma/table lookup,
  with an AHB-Lite register slave and a two-entry output buffer.
  Assumes one clock, single whole-word bus transfers, synchronous pixels.
*/
// Chosen here: the AHB-Lite register port and the address map.
// Functional notes
// - Clip selector addresses all, R, G, B, Y, U, V, tap1 or tap2.
// - All-channel clip level is its own setting, not broadcast.
// - Each pixel saturates at the lower of its own and the all-channel clip level.
// - Ratio selector addresses all, R, G, B, Y, U, V, tap1 or tap2.
// - Sample is multiplied by its strictly positive balance ratio.
// - Auto white off keeps ratios as software wrote them.
// - Auto white once adjusts until converged, then returns to off.
// - Auto white continuous keeps adjusting while selected.
// - Output intensity is input raised to a positive gamma factor; the gamma value is only stored, and the curve comes from the luminance table.
// - Gamma uses the luminance table, which then refuses writes.
// - Table selector picks luminance, red, green or blue table.
// - Table selector would be absent with a single table.
// - Outside gamma, a table applies only while its enable is set.
// - Each table holds its own non-negative entry index.
// - Table value reads or replaces the entry at the current index.
`timescale 1ns/1ps
`default_nettype none
module ptc_top
  import ptc_pkg::*;
(
  input  wire logic             sys_clk_i,
  input  wire logic             rst_n_i,
  input  wire logic             hsel_i,
  input  wire logic [31:0]      haddr_i,
  input  wire logic [1:0]       htrans_i,
  input  wire logic             hwrite_i,
  input  wire logic [2:0]       hsize_i,
  input  wire logic [31:0]      hwdata_i,
  input  wire logic             hready_i,
  output logic                  hreadyout_o,
  output logic                  hresp_o,
  output logic [31:0]           hrdata_o,
  input  wire ptc_pkg::ptc_pix_s pix_in_i,
  input  wire logic             pix_valid_i,
  output logic                  pix_ready_o,
  output ptc_pkg::ptc_pix_s     pix_out_o,
  output logic                  pix_valid_o,
  input  wire logic             pix_ready_i
);
  import ptc_pkg::*;

  function automatic logic [3:0] ch_idx(input logic [3:0] c);
    ch_idx = (c > PTC_CH_TAP2) ? PTC_CH_ALL : c;
  endfunction : ch_idx

  function automatic logic [1:0] tbl_of(input logic [3:0] c);
    tbl_of = (c == PTC_CH_RED || c == PTC_CH_GREEN || c == PTC_CH_BLUE) ? c[1:0] : 2'h0;
  endfunction : tbl_of

  function automatic logic [7:0] sat8(input logic [23:0] p);
    sat8 = (p[23:16] != 8'h00) ? 8'hff : p[15:8];
  endfunction : sat8

  ptc_bus_e    st, next_st;
  logic [7:0]  addr, next_addr;
  logic        wr, next_wr;
  logic [31:0] rdata, next_rdata;
  logic [7:0]  clip [PTC_NCH], next_clip [PTC_NCH];
  logic [15:0] ratio [PTC_NCH], next_ratio [PTC_NCH];
  logic [3:0]  clip_channel_select, next_clip_sel;
  logic [3:0]  ratio_channel_select, next_ratio_sel;
  ptc_awb_e    auto_white_mode, next_awb;
  logic [15:0] gamma, next_gamma;
  logic        gamma_on, next_gamma_on;
  logic [1:0]  table_select, next_tsel;
  logic [3:0]  table_enable, next_ten;
  logic [7:0]  tidx [PTC_TABLES], next_tidx [PTC_TABLES];
  logic [15:0] sum_r, sum_g, sum_b, next_sum_r, next_sum_g, next_sum_b;
  logic [7:0]  awb_cnt, next_awb_cnt;
  logic        awb_conv;
  logic [7:0]  lut [1024];
  logic        lut_we;
  logic [9:0]  lut_wa;
  logic [7:0]  table_entry_value;
  logic        in_fire;

  // Current entry of the selected table; index is per table
  assign table_entry_value = lut[{table_select, tidx[table_select]}];
  assign in_fire = pix_valid_i && pix_ready_o;
  assign hreadyout_o = (st != PTC_BS_ACC); // One wait state per transfer
  assign hresp_o = 1'b0;
  assign hrdata_o = rdata;

  // Bus slave, settings and auto white balance share one next-state process,
  // since the balancer and software both write the ratio table
  always_comb
  begin
    logic [31:0] rd;
    logic        req;
    rd = 32'h0000_0000;
    req = hsel_i && htrans_i[1] && hready_i;
    next_st = st;
    next_addr = addr;
    next_wr = wr;
    next_rdata = rdata;
    next_clip = clip;
    next_ratio = ratio;
    next_clip_sel = clip_channel_select;
    next_ratio_sel = ratio_channel_select;
    next_awb = auto_white_mode;
    next_gamma = gamma;
    next_gamma_on = gamma_on;
    next_tsel = table_select;
    next_ten = table_enable;
    next_tidx = tidx;
    next_sum_r = sum_r;
    next_sum_g = sum_g;
    next_sum_b = sum_b;
    next_awb_cnt = awb_cnt;
    awb_conv = 1'b0;
    lut_we = 1'b0;
    lut_wa = {table_select, tidx[table_select]};
    unique case (addr)
      PTC_A_CLIP_SEL:  rd = {28'h0, clip_channel_select};
      PTC_A_CLIP:      rd = {24'h0, clip[ch_idx(clip_channel_select)]};
      PTC_A_RATIO_SEL: rd = {28'h0, ratio_channel_select};
      PTC_A_RATIO:     rd = {16'h0, ratio[ch_idx(ratio_channel_select)]};
      PTC_A_AWB:       rd = {30'h0, auto_white_mode};
      PTC_A_GAMMA:     rd = {16'h0, gamma};
      PTC_A_GAMMA_ON:  rd = {31'h0, gamma_on};
      PTC_A_TSEL:      rd = {30'h0, table_select};
      PTC_A_TEN:       rd = {31'h0, table_enable[table_select]};
      PTC_A_TIDX:      rd = {24'h0, tidx[table_select]};
      PTC_A_TVAL:      rd = {24'h0, table_entry_value};
      PTC_A_STATUS:    rd = {29'h0, pix_valid_o, pix_ready_o, auto_white_mode != PTC_AW_OFF};
      default:         rd = 32'h0000_0000; // Unmapped reads as zero
    endcase
    // Balancer: gather R/G/B sums over a window, then nudge red and blue
    // toward green by one step; coarse, but it cannot oscillate far
    if (auto_white_mode == PTC_AW_OFF)
    begin
      next_sum_r = 16'h0000;
      next_sum_g = 16'h0000;
      next_sum_b = 16'h0000;
      next_awb_cnt = 8'h00;
    end
    else if (in_fire)
    begin
      next_awb_cnt = awb_cnt + 8'h01;
      if (pix_in_i.chan == PTC_CH_RED)
        next_sum_r = sum_r + {8'h00, pix_in_i.data};
      if (pix_in_i.chan == PTC_CH_GREEN)
        next_sum_g = sum_g + {8'h00, pix_in_i.data};
      if (pix_in_i.chan == PTC_CH_BLUE)
        next_sum_b = sum_b + {8'h00, pix_in_i.data};
      if (awb_cnt == PTC_AWB_LAST)
      begin
        next_sum_r = 16'h0000;
        next_sum_g = 16'h0000;
        next_sum_b = 16'h0000;
        // One guard bit, so a bright window cannot wrap the tolerance sum
        awb_conv = ({1'b0, sum_r} + {1'b0, PTC_AWB_TOL} > {1'b0, sum_g})
                && ({1'b0, sum_g} + {1'b0, PTC_AWB_TOL} > {1'b0, sum_r})
                && ({1'b0, sum_b} + {1'b0, PTC_AWB_TOL} > {1'b0, sum_g})
                && ({1'b0, sum_g} + {1'b0, PTC_AWB_TOL} > {1'b0, sum_b});
        if (sum_r < sum_g && ratio[PTC_CH_RED] != 16'hffff)
          next_ratio[PTC_CH_RED] = ratio[PTC_CH_RED] + 16'h0001;
        else if (sum_r > sum_g && ratio[PTC_CH_RED] > 16'h0001)
          next_ratio[PTC_CH_RED] = ratio[PTC_CH_RED] - 16'h0001;
        if (sum_b < sum_g && ratio[PTC_CH_BLUE] != 16'hffff)
          next_ratio[PTC_CH_BLUE] = ratio[PTC_CH_BLUE] + 16'h0001;
        else if (sum_b > sum_g && ratio[PTC_CH_BLUE] > 16'h0001)
          next_ratio[PTC_CH_BLUE] = ratio[PTC_CH_BLUE] - 16'h0001;
        if (awb_conv && auto_white_mode == PTC_AW_ONCE)
          next_awb = PTC_AW_OFF;
      end
    end
    unique case (st)
      PTC_BS_IDLE, PTC_BS_DONE:
      begin
        next_st = req ? PTC_BS_ACC : PTC_BS_IDLE;
        if (req)
        begin
          next_addr = haddr_i[7:0];
          next_wr = hwrite_i;
        end
      end
      PTC_BS_ACC:
      begin
        next_st = PTC_BS_DONE;
        next_rdata = wr ? 32'h0000_0000 : rd;
        if (wr)
        begin
          unique case (addr)
            PTC_A_CLIP_SEL:  next_clip_sel = (hwdata_i[3:0] > PTC_CH_TAP2) ?
                                             clip_channel_select : hwdata_i[3:0];
            PTC_A_CLIP:      next_clip[ch_idx(clip_channel_select)] = hwdata_i[7:0];
            PTC_A_RATIO_SEL: next_ratio_sel = (hwdata_i[3:0] > PTC_CH_TAP2) ?
                                              ratio_channel_select : hwdata_i[3:0];
            PTC_A_RATIO:
              if (hwdata_i[15:0] != 16'h0000)
                next_ratio[ch_idx(ratio_channel_select)] = hwdata_i[15:0];
            PTC_A_AWB:
              if (hwdata_i[1:0] != 2'h3)
                next_awb = ptc_awb_e'(hwdata_i[1:0]);
            PTC_A_GAMMA:
              if (hwdata_i[15:0] != 16'h0000)
                next_gamma = hwdata_i[15:0];
            PTC_A_GAMMA_ON:  next_gamma_on = hwdata_i[0];
            PTC_A_TSEL:      next_tsel = (PTC_TABLES > 1) ? hwdata_i[1:0] : 2'h0;
            PTC_A_TEN:       next_ten[table_select] = hwdata_i[0];
            PTC_A_TIDX:      next_tidx[table_select] = hwdata_i[7:0];
            PTC_A_TVAL:      lut_we = !(gamma_on && table_select == 2'h0);
            default:         lut_we = 1'b0;
          endcase
        end
      end
      default: next_st = PTC_BS_IDLE;
    endcase
  end

  // Register the bus and settings group
  always_ff @(posedge sys_clk_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
    begin
      st <= PTC_BS_IDLE;
      addr <= 8'h00;
      wr <= 1'b0;
      rdata <= 32'h0000_0000;
      for (int i = 0; i < PTC_NCH; i++)
      begin
        clip[i] <= PTC_CLIP_RST;
        ratio[i] <= PTC_RATIO_RST;
      end
      clip_channel_select <= PTC_CH_ALL;
      ratio_channel_select <= PTC_CH_ALL;
      auto_white_mode <= PTC_AW_OFF;
      gamma <= PTC_GAMMA_RST;
      gamma_on <= 1'b0;
      table_select <= 2'h0;
      table_enable <= 4'h0;
      for (int i = 0; i < PTC_TABLES; i++)
        tidx[i] <= 8'h00;
      sum_r <= 16'h0000;
      sum_g <= 16'h0000;
      sum_b <= 16'h0000;
      awb_cnt <= 8'h00;
    end
    else
    begin
      st <= next_st;
      addr <= next_addr;
      wr <= next_wr;
      rdata <= next_rdata;
      clip <= next_clip;
      ratio <= next_ratio;
      clip_channel_select <= next_clip_sel;
      ratio_channel_select <= next_ratio_sel;
      auto_white_mode <= next_awb;
      gamma <= next_gamma;
      gamma_on <= next_gamma_on;
      table_select <= next_tsel;
      table_enable <= next_ten;
      tidx <= next_tidx;
      sum_r <= next_sum_r;
      sum_g <= next_sum_g;
      sum_b <= next_sum_b;
      awb_cnt <= next_awb_cnt;
    end
  end

  // Table memory has no reset; software loads it before enabling
  always_ff @(posedge sys_clk_i)
  begin
    if (lut_we)
      lut[lut_wa] <= hwdata_i[7:0];
  end

  ptc_pix_s s1, s2, s3, next_s1, next_s2, next_s3;
  logic     v1, v2, v3, next_v1, next_v2, next_v3;
  ptc_pix_s bq [2], next_bq [2];
  logic [1:0] bcnt, next_bcnt;
  logic     adv;

  // Whole pipe stalls while the buffer is full, so no word is dropped
  assign adv = (bcnt != PTC_BUF_DEPTH);
  assign pix_ready_o = adv;
  assign pix_valid_o = (bcnt != 2'h0);
  assign pix_out_o = bq[0];

  // Pixel pipe: ratio, then clip, then table, then buffer
  always_comb
  begin
    logic [1:0] t;
    logic [7:0] lim;
    logic [1:0] n;
    t = gamma_on ? 2'h0 : tbl_of(s2.chan);
    lim = clip[ch_idx(s1.chan)];
    n = bcnt;
    next_s1 = s1;
    next_s2 = s2;
    next_s3 = s3;
    next_v1 = v1;
    next_v2 = v2;
    next_v3 = v3;
    next_bq = bq;
    if (clip[PTC_CH_ALL] < lim)
      lim = clip[PTC_CH_ALL];
    if (adv)
    begin
      next_v1 = pix_valid_i;
      next_v2 = v1;
      next_v3 = v2;
      next_s1.chan = pix_in_i.chan;
      next_s1.data = sat8({16'h0000, pix_in_i.data}
                          * {8'h00, ratio[ch_idx(pix_in_i.chan)]});
      next_s2.chan = s1.chan;
      next_s2.data = (s1.data > lim) ? lim : s1.data;
      next_s3.chan = s2.chan;
      next_s3.data = (gamma_on || table_enable[t]) ? lut[{t, s2.data}] : s2.data;
    end
    if (pix_valid_o && pix_ready_i)
    begin
      next_bq[0] = bq[1];
      n = n - 2'h1;
    end
    if (adv && v3)
    begin
      next_bq[n[0]] = s3;
      n = n + 2'h1;
    end
    next_bcnt = n;
  end

  // Register the pixel pipe and buffer
  always_ff @(posedge sys_clk_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
    begin
      s1 <= '0;
      s2 <= '0;
      s3 <= '0;
      v1 <= 1'b0;
      v2 <= 1'b0;
      v3 <= 1'b0;
      bq[0] <= '0;
      bq[1] <= '0;
      bcnt <= 2'h0;
    end
    else
    begin
      s1 <= next_s1;
      s2 <= next_s2;
      s3 <= next_s3;
      v1 <= next_v1;
      v2 <= next_v2;
      v3 <= next_v3;
      bq <= next_bq;
      bcnt <= next_bcnt;
    end
  end

  default clocking cb @(posedge sys_clk_i); endclocking
  default disable iff (!rst_n_i);

  property p_clip;
    v2 |-> s2.data <= clip[ch_idx(s2.chan)] && s2.data <= clip[PTC_CH_ALL];
  endproperty
  a_clip: assert property (p_clip) else $error("clip exceeded");
  property p_ratio;
    in_fire |=> s1.data == sat8({16'h0000, $past(pix_in_i.data)}
      * {8'h00, $past(ratio[PTC_CH_RED])}) || $past(pix_in_i.chan) != PTC_CH_RED;
  endproperty
  a_ratio: assert property (p_ratio) else $error("ratio product wrong");
  property p_ratio_pos;
    ratio[ch_idx(ratio_channel_select)] != 16'h0000 && gamma != 16'h0000;
  endproperty
  a_ratio_pos: assert property (p_ratio_pos) else $error("zero factor");
  property p_off;
    auto_white_mode == PTC_AW_OFF && st != PTC_BS_ACC |=> $stable(ratio[PTC_CH_RED]);
  endproperty
  a_off: assert property (p_off) else $error("ratio moved while off");
  property p_once;
    auto_white_mode == PTC_AW_ONCE && in_fire && awb_conv && !(st == PTC_BS_ACC && wr)
      |=> auto_white_mode == PTC_AW_OFF;
  endproperty
  a_once: assert property (p_once) else $error("once did not return off");
  property p_cont;
    auto_white_mode == PTC_AW_CONT && !(st == PTC_BS_ACC && wr)
      |=> auto_white_mode == PTC_AW_CONT;
  endproperty
  a_cont: assert property (p_cont) else $error("continuous left");
  property p_pass;
    adv && v2 && !gamma_on && !table_enable[tbl_of(s2.chan)] |=> s3.data == $past(s2.data);
  endproperty
  a_pass: assert property (p_pass) else $error("disabled table altered pixel");
  property p_lat;
    in_fire ##1 adv ##1 adv |=> v3;
  endproperty
  a_lat: assert property (p_lat) else $error("latency broken");
  property p_bus;
    st == PTC_BS_ACC |-> !hreadyout_o ##1 hreadyout_o;
  endproperty
  a_bus: assert property (p_bus) else $error("bus wait state wrong");
  property p_lum_lock;
    gamma_on && table_select == 2'h0 |-> !lut_we;
  endproperty
  a_lum_lock: assert property (p_lum_lock) else $error("luminance table written");
  c_stall: cover property (pix_valid_o && !pix_ready_i [*3]);
  c_once: cover property (auto_white_mode == PTC_AW_ONCE ##1 auto_white_mode == PTC_AW_OFF);
  c_table: cover property (v3 && table_enable[1]);
endmodule : ptc_top
`default_nettype wire

// File: src/ptc_pkg.sv
/*
  Constants, types and register map of the pixel tone correction stage.
  Assumes a 32-bit AHB-Lite fabric with byte addresses in the low eight bits.
*/
package ptc_pkg;
  // Register byte offsets
  localparam logic [7:0] PTC_A_CLIP_SEL  = 8'h00;
  localparam logic [7:0] PTC_A_CLIP      = 8'h04;
  localparam logic [7:0] PTC_A_RATIO_SEL = 8'h08;
  localparam logic [7:0] PTC_A_RATIO     = 8'h0c;
  localparam logic [7:0] PTC_A_AWB       = 8'h10;
  localparam logic [7:0] PTC_A_GAMMA     = 8'h14;
  localparam logic [7:0] PTC_A_GAMMA_ON  = 8'h18;
  localparam logic [7:0] PTC_A_TSEL      = 8'h1c;
  localparam logic [7:0] PTC_A_TEN       = 8'h20;
  localparam logic [7:0] PTC_A_TIDX      = 8'h24;
  localparam logic [7:0] PTC_A_TVAL      = 8'h28;
  localparam logic [7:0] PTC_A_STATUS    = 8'h2c;
  // Reset values and counts
  localparam logic [15:0] PTC_RATIO_RST = 16'h0100;
  localparam logic [7:0]  PTC_CLIP_RST  = 8'hff;
  localparam logic [15:0] PTC_GAMMA_RST = 16'h0100;
  localparam logic [7:0]  PTC_AWB_LAST  = 8'hff;
  localparam logic [15:0] PTC_AWB_TOL   = 16'h0100;
  localparam int          PTC_NCH       = 9;
  localparam int          PTC_TABLES    = 4;
  localparam logic [1:0]  PTC_BUF_DEPTH = 2'h2;
  typedef enum logic [3:0] {
    PTC_CH_ALL = 4'h0, PTC_CH_RED = 4'h1, PTC_CH_GREEN = 4'h2,
    PTC_CH_BLUE = 4'h3, PTC_CH_Y = 4'h4, PTC_CH_U = 4'h5,
    PTC_CH_V = 4'h6, PTC_CH_TAP1 = 4'h7, PTC_CH_TAP2 = 4'h8
  } ptc_chan_e;
  typedef enum logic [1:0] {
    PTC_AW_OFF = 2'h0, PTC_AW_ONCE = 2'h1, PTC_AW_CONT = 2'h2
  } ptc_awb_e;
  typedef enum logic [1:0] {
    PTC_BS_IDLE = 2'h0, PTC_BS_ACC = 2'h1, PTC_BS_DONE = 2'h2
  } ptc_bus_e;
  typedef struct packed {
    logic [3:0] chan;
    logic [7:0] data;
  } ptc_pix_s;
endpackage : ptc_pkg

// File: test/ptc_pix_src.sv
/*
  Upstream pixel source model for the tone correction stage.
  Assumes the bench fills its queue and seeds the random generator once.
*/
`timescale 1ns/1ps
`default_nettype none
module ptc_pix_src
  import ptc_pkg::*;
(
  input  wire logic         clk_i,
  input  wire logic         rst_n_i,
  input  wire logic         ready_i,
  output ptc_pkg::ptc_pix_s pix_o,
  output logic              valid_o
);
  ptc_pix_s q[$];
  // Holds a word until taken; random gaps give both bursts and idle cycles
  always @(posedge clk_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
    begin
      valid_o <= 1'b0;
      pix_o   <= '0;
    end
    else if (!valid_o || ready_i)
    begin
      if (valid_o)
        void'(q.pop_front());
      if (q.size() > 0 && $urandom_range(3) != 0)
      begin
        valid_o <= 1'b1;
        pix_o   <= q[0];
      end
      else
      begin
        valid_o <= 1'b0;
        pix_o   <= ~pix_o; // Idle data toggles so nobody can rely on it
      end
    end
  end
endmodule : ptc_pix_src
`default_nettype wire

// File: test/ptc_top_tb_top.sv
/*
  Self-checking bench of the tone correction stage: AHB-Lite master tasks,
  a pixel scoreboard fed by a reference model, random downstream stalls.
  Assumes one 40 MHz clock and hready looped back from the single slave.
*/
`timescale 1ns/1ps
`default_nettype none
module ptc_top_tb_top;
  import ptc_pkg::*;
  logic        sys_clk_i = 1'b0;
  logic        rst_n_i   = 1'b0;
  logic        hsel_i    = 1'b0;
  logic        hwrite_i  = 1'b0;
  logic [1:0]  htrans_i  = 2'h0;
  logic [31:0] haddr_i   = 32'h0;
  logic [31:0] hwdata_i  = 32'h0;
  logic        pix_ready_i = 1'b0;
  logic        stall     = 1'b0;
  logic        hreadyout_o, hresp_o, pix_ready_o, pix_valid_o, pix_valid_i;
  logic [31:0] hrdata_o, rd;
  ptc_pix_s    pix_in_i, pix_out_o;
  ptc_pix_s    exq[$];
  logic [15:0] ratio[9];
  logic [7:0]  clip[9];
  logic [7:0]  lut[4][256];
  logic        ten[4];
  logic        gon = 1'b0;
  int          num_errors = 0;
  int          compares = 0;

  ptc_top u_ptc_top (.sys_clk_i(sys_clk_i), .rst_n_i(rst_n_i), .hsel_i(hsel_i),
    .haddr_i(haddr_i), .htrans_i(htrans_i), .hwrite_i(hwrite_i), .hsize_i(3'h2),
    .hwdata_i(hwdata_i), .hready_i(hreadyout_o), .hreadyout_o(hreadyout_o),
    .hresp_o(hresp_o), .hrdata_o(hrdata_o), .pix_in_i(pix_in_i),
    .pix_valid_i(pix_valid_i), .pix_ready_o(pix_ready_o), .pix_out_o(pix_out_o),
    .pix_valid_o(pix_valid_o), .pix_ready_i(pix_ready_i));
  ptc_pix_src u_ptc_pix_src (.clk_i(sys_clk_i), .rst_n_i(rst_n_i), .ready_i(pix_ready_o),
    .pix_o(pix_in_i), .valid_o(pix_valid_i));

  always #12.5 sys_clk_i = ~sys_clk_i;

  // Downstream stalls at random, or for good while the buffer is being filled
  always @(posedge sys_clk_i)
    pix_ready_i <= !stall && ($urandom_range(3) != 0);

  task automatic chk(input logic [31:0] seen, input logic [31:0] want);
    compares++;
    if (seen !== want)
    begin
      num_errors++;
      $display("ERROR %0t: saw %h expected %h", $time, seen, want);
    end
  endtask : chk

  // Single whole-word transfer; waits for hready in both phases
  task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] wd);
    hsel_i   <= 1'b1;
    htrans_i <= 2'h2;
    hwrite_i <= w;
    haddr_i  <= {24'h0, a};
    @(posedge sys_clk_i);
    while (hreadyout_o !== 1'b1) @(posedge sys_clk_i);
    htrans_i <= 2'h0;
    hsel_i   <= 1'b0;
    hwdata_i <= wd;
    @(posedge sys_clk_i);
    while (hreadyout_o !== 1'b1) @(posedge sys_clk_i);
    rd = hrdata_o;
  endtask : bus

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    bus(1'b1, a, d);
  endtask : wr

  task automatic rdc(input logic [7:0] a, input logic [31:0] want);
    bus(1'b0, a, 32'h0);
    chk(rd, want);
  endtask : rdc

  // Reference: ratio in 8.8 with saturation, own and all clip, then table
  function automatic ptc_pix_s pix_model(input ptc_pix_s p);
    logic [3:0]  c;
    logic [23:0] t;
    logic [1:0]  tb;
    c = (p.chan > 4'h8) ? 4'h0 : p.chan;
    t = ({16'h0, p.data} * {8'h0, ratio[c]}) >> 8;
    if (t > 24'hff) t = 24'hff;
    if (t[7:0] > clip[c]) t = {16'h0, clip[c]};
    if (t[7:0] > clip[0]) t = {16'h0, clip[0]};
    // Gamma routes every channel through the luminance table
    tb = gon ? 2'h0 : ((c >= 4'h1 && c <= 4'h3) ? c[1:0] : 2'h0);
    if (gon || ten[tb]) t = {16'h0, lut[tb][t[7:0]]};
    return {p.chan, t[7:0]};
  endfunction : pix_model

  // A negative channel or data argument asks for a random one
  task automatic send(input int n, input int ch = -1, input int dv = -1);
    ptc_pix_s p;
    repeat (n)
    begin
      p.chan = (ch < 0) ? 4'($urandom_range(8)) : 4'(ch);
      p.data = (dv < 0) ? 8'($urandom) : 8'(dv);
      exq.push_back(pix_model(p));
      u_ptc_pix_src.q.push_back(p);
    end
  endtask : send

  task automatic drain();
    for (int i = 0; i < 3000 && exq.size() > 0; i++) @(posedge sys_clk_i);
    chk(32'(exq.size()), 32'h0);
  endtask : drain

  // Scoreboard: every accepted output word meets the oldest expectation
  always @(posedge sys_clk_i)
  begin
    if (pix_valid_o === 1'b1 && pix_ready_i === 1'b1)
    begin
      if (exq.size() == 0)
        chk({20'h0, pix_out_o}, 32'hffffffff);
      else
        chk({20'h0, pix_out_o}, {20'h0, exq.pop_front()});
    end
  end

  task automatic conclude();
    $display("errors %0d compares %0d", num_errors, compares);
    if (num_errors == 0 && compares > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask : conclude

  // Watchdog well beyond the roughly 4500 cycles the sequence needs
  initial
  begin
    #500000;
    num_errors++;
    conclude();
  end

  initial
  begin
    void'($urandom(32'hc491a9e5));
    for (int c = 0; c < 9; c++)
    begin
      ratio[c] = PTC_RATIO_RST;
      clip[c]  = PTC_CLIP_RST;
    end
    for (int t = 0; t < 4; t++) ten[t] = 1'b0;
    repeat (3) @(posedge sys_clk_i);
    rst_n_i <= 1'b1;
    @(posedge sys_clk_i);
    // Reset values, unmapped place and refused writes
    rdc(PTC_A_CLIP, 32'hff);
    rdc(PTC_A_RATIO, 32'h100);
    rdc(PTC_A_GAMMA, 32'h100);
    rdc(PTC_A_TIDX, 32'h0);
    rdc(PTC_A_STATUS, 32'h2);
    rdc(8'h40, 32'h0);
    chk({31'h0, hresp_o}, 32'h0);
    wr(PTC_A_RATIO, 32'h0);
    rdc(PTC_A_RATIO, 32'h100);
    wr(PTC_A_GAMMA, 32'h0);
    rdc(PTC_A_GAMMA, 32'h100);
    wr(PTC_A_CLIP_SEL, 32'h9);
    rdc(PTC_A_CLIP_SEL, 32'h0);
    wr(PTC_A_AWB, 32'h3);
    rdc(PTC_A_AWB, 32'h0);
    // Every selector code gets its own clip level and ratio
    for (int c = 0; c < 9; c++)
    begin
      clip[c]  = 8'($urandom_range(255, 64));
      ratio[c] = 16'($urandom_range(768, 1));
      wr(PTC_A_CLIP_SEL, 32'(c));
      wr(PTC_A_CLIP, {24'h0, clip[c]});
      wr(PTC_A_RATIO_SEL, 32'(c));
      wr(PTC_A_RATIO, {16'h0, ratio[c]});
    end
    for (int c = 0; c < 9; c++)
    begin
      wr(PTC_A_CLIP_SEL, 32'(c));
      rdc(PTC_A_CLIP, {24'h0, clip[c]});
      wr(PTC_A_RATIO_SEL, 32'(c));
      rdc(PTC_A_RATIO, {16'h0, ratio[c]});
    end
    send(40);
    drain();
    // Receiver stalls: buffer fills and refuses, nothing is lost
    stall <= 1'b1;
    send(8);
    repeat (30) @(posedge sys_clk_i);
    chk({31'h0, pix_ready_o}, 32'h0);
    stall <= 1'b0;
    drain();
    // Auto white: a dark green window converges at once, a bright one
    // pulls red and blue up one step each; green pixels keep the model exact
    wr(PTC_A_AWB, 32'h1);
    rdc(PTC_A_STATUS, 32'h3);
    send(256, 2, 0);
    drain();
    rdc(PTC_A_AWB, 32'h0);
    wr(PTC_A_AWB, 32'h2);
    send(256, 2, -1);
    drain();
    rdc(PTC_A_AWB, 32'h2);
    wr(PTC_A_AWB, 32'h0);
    ratio[1] = ratio[1] + 16'h0001;
    ratio[3] = ratio[3] + 16'h0001;
    for (int c = 1; c < 4; c += 2)
    begin
      wr(PTC_A_RATIO_SEL, 32'(c));
      rdc(PTC_A_RATIO, {16'h0, ratio[c]});
    end
    // Load red and blue tables, each index left at its own place
    for (int t = 1; t < 4; t += 2)
    begin
      wr(PTC_A_TSEL, 32'(t));
      for (int i = 0; i < 256; i++)
      begin
        lut[t][i] = 8'($urandom);
        wr(PTC_A_TIDX, 32'(i));
        wr(PTC_A_TVAL, {24'h0, lut[t][i]});
      end
      wr(PTC_A_TIDX, 32'(t + 6));
      rdc(PTC_A_TVAL, {24'h0, lut[t][t + 6]});
      wr(PTC_A_TEN, 32'h1);
      ten[t] = 1'b1;
      rdc(PTC_A_TEN, 32'h1);
    end
    wr(PTC_A_TSEL, 32'h1);
    rdc(PTC_A_TIDX, 32'h7);
    send(60);
    drain();
    // Gamma owns the luminance table and locks out its writes
    wr(PTC_A_TSEL, 32'h0);
    wr(PTC_A_TIDX, 32'h0);
    wr(PTC_A_TVAL, 32'h11);
    wr(PTC_A_GAMMA_ON, 32'h1);
    wr(PTC_A_TVAL, 32'h22);
    rdc(PTC_A_TVAL, 32'h11);
    // Black pixels under gamma all map through luminance entry zero
    lut[0][0] = 8'h11;
    gon = 1'b1;
    send(8, -1, 0);
    drain();
    wr(PTC_A_GAMMA_ON, 32'h0);
    gon = 1'b0;
    conclude();
  end
endmodule : ptc_top_tb_top
`default_nettype wire
